// ### rtl/cisf_map.vh
/*
  flag positions and reset value for the can interrupt status flag block.
  assumes inclusion by bare name from design files under rtl/.
*/
`ifndef CISF_MAP_VH
`define CISF_MAP_VH
`define CISF_BIT_RAM_WATCHDOG 26
`define CISF_BIT_BUS_OFF_CHG 25
`define CISF_BIT_WARNING_CHG 24
`define CISF_BIT_PASSIVE_CHG 23
`define CISF_BIT_LOG_OVERFLOW 22
`define CISF_BIT_DEDICATED_RX 19
`define CISF_BIT_TIMEOUT 18
`define CISF_BIT_ACCESS_FAIL 17
`define CISF_FLAG_RESET 32'h00000000
`endif

// ### rtl/cisf_flag.v
/*
  one sticky flag: set by a hardware event, cleared by software.
  assumes synchronous event and clear pulses, reset already synchronised.
*/
`timescale 1ns/100ps
`default_nettype none
module cisf_flag (
  input wire clk_in,
  input wire rst_n_in,
  input wire set_in,
  input wire clr_in,
  output reg flag_out
);
  // set beats a clear in the same cycle
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flag_out <= 1'b0;
    end else if (set_in) begin
      flag_out <= 1'b1;
    end else if (clr_in) begin
      flag_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### rtl/cisf_top.v
/*
  can interrupt status flags: eight sticky flags in a 32-bit flag word,
  plus the receive storage abort control that goes with the access failure flag.
  a flag shows in the word two edges after its event and holds until cleared.
  the state change flags come from edges on the bus-off, warning and passive levels.
  assumes all event inputs are single-cycle pulses synchronous to ref_clk_in,
  the state inputs are levels, and a clear bit is a one-cycle pulse per flag.
  assumes the receive handler drops its own partial frame when store_abort_out pulses.
  assumes no clock enable: every register runs on every edge.
*/
`timescale 1ns/100ps
`default_nettype none
`include "cisf_map.vh"
module cisf_top #(
  parameter IDX_W = 6
) (
  input wire ref_clk_in,
  input wire rst_n_in,
  input wire ram_watchdog_expired_in,
  input wire bus_off_in,
  input wire error_warning_in,
  input wire error_passive_in,
  input wire error_log_overflow_in,
  input wire store_busy_in,
  input wire store_done_in,
  input wire store_dedicated_in,
  input wire [IDX_W-1:0] store_index_in,
  input wire next_arbitration_done_in,
  input wire ram_write_fail_in,
  input wire timeout_reached_in,
  input wire [31:0] flag_clear_in,
  output reg [31:0] flag_word_out,
  output reg store_abort_out,
  output reg fifo_put_advance_out,
  output reg new_data_set_out,
  output reg [IDX_W-1:0] new_data_index_out,
  output reg [IDX_W-1:0] fifo_put_index_out
);
  // synchronised reset and previous state levels
  reg rst_meta;
  reg rst_sync;
  reg bus_off_prev;
  reg warning_prev;
  reg passive_prev;
  reg state_seen;
  // sticky flag copies, one per event source
  wire ram_watchdog_flag;
  wire bus_off_change_flag;
  wire error_warning_change_flag;
  wire error_passive_change_flag;
  wire error_log_overflow_flag;
  wire dedicated_buffer_stored_flag;
  wire timeout_reached_flag;
  wire ram_access_failure_flag;
  wire [7:0] set_vec;
  wire [7:0] clr_vec;
  // store decode and next values of the store controls
  wire abort_now;
  wire store_ok;
  wire store_to_buffer;
  wire store_to_fifo;
  wire next_store_abort;
  wire next_put_advance;
  wire next_new_data_set;
  wire [IDX_W-1:0] next_put_index;
  reg [31:0] next_flag_word;

  // first stage of the reset release; may go metastable on a late release
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
    end
  end

  // second stage: the only reader of the first, feeds every other reset
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_sync <= 1'b0;
    end else begin
      rst_sync <= rst_meta;
    end
  end

  // bus-off level from the previous edge
  always @(posedge ref_clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      bus_off_prev <= 1'b0;
    end else begin
      bus_off_prev <= bus_off_in;
    end
  end

  // warning level from the previous edge
  always @(posedge ref_clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      warning_prev <= 1'b0;
    end else begin
      warning_prev <= error_warning_in;
    end
  end

  // passive level from the previous edge
  always @(posedge ref_clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      passive_prev <= 1'b0;
    end else begin
      passive_prev <= error_passive_in;
    end
  end

  // first sample after reset only primes the levels, so no false change follows reset
  always @(posedge ref_clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      state_seen <= 1'b0;
    end else begin
      state_seen <= 1'b1;
    end
  end

  // abort on late filtering or failed ram write; a store finishing alongside is dropped
  assign abort_now = (store_busy_in & next_arbitration_done_in) | ram_write_fail_in;
  assign store_ok = store_done_in & ~abort_now;
  assign store_to_buffer = store_ok & store_dedicated_in;
  assign store_to_fifo = store_ok & ~store_dedicated_in;

  // next values of the store controls; an abort commits nothing, the slot is reused
  assign next_store_abort = abort_now;
  assign next_put_advance = store_to_fifo;
  assign next_new_data_set = store_to_buffer;
  assign next_put_index = fifo_put_index_out + {{(IDX_W-1){1'b0}}, 1'b1};

  // hardware set events, one per flag, order matches clr_vec
  assign set_vec[7] = ram_watchdog_expired_in;
  assign set_vec[6] = state_seen & (bus_off_in ^ bus_off_prev);
  assign set_vec[5] = state_seen & (error_warning_in ^ warning_prev);
  assign set_vec[4] = state_seen & (error_passive_in ^ passive_prev);
  assign set_vec[3] = error_log_overflow_in;
  assign set_vec[2] = store_to_buffer;
  assign set_vec[1] = timeout_reached_in;
  assign set_vec[0] = abort_now;

  // software clear lanes taken from the flag positions in the word
  assign clr_vec[7] = flag_clear_in[`CISF_BIT_RAM_WATCHDOG];
  assign clr_vec[6] = flag_clear_in[`CISF_BIT_BUS_OFF_CHG];
  assign clr_vec[5] = flag_clear_in[`CISF_BIT_WARNING_CHG];
  assign clr_vec[4] = flag_clear_in[`CISF_BIT_PASSIVE_CHG];
  assign clr_vec[3] = flag_clear_in[`CISF_BIT_LOG_OVERFLOW];
  assign clr_vec[2] = flag_clear_in[`CISF_BIT_DEDICATED_RX];
  assign clr_vec[1] = flag_clear_in[`CISF_BIT_TIMEOUT];
  assign clr_vec[0] = flag_clear_in[`CISF_BIT_ACCESS_FAIL];

  // ram watchdog flag
  cisf_flag u_ram_watchdog (
    .clk_in(ref_clk_in),
    .rst_n_in(rst_sync),
    .set_in(set_vec[7]),
    .clr_in(clr_vec[7]),
    .flag_out(ram_watchdog_flag)
  );

  // bus-off change flag
  cisf_flag u_bus_off_change (
    .clk_in(ref_clk_in),
    .rst_n_in(rst_sync),
    .set_in(set_vec[6]),
    .clr_in(clr_vec[6]),
    .flag_out(bus_off_change_flag)
  );

  // warning change flag, kept apart from the other two state flags
  cisf_flag u_warning_change (
    .clk_in(ref_clk_in),
    .rst_n_in(rst_sync),
    .set_in(set_vec[5]),
    .clr_in(clr_vec[5]),
    .flag_out(error_warning_change_flag)
  );

  // passive change flag
  cisf_flag u_passive_change (
    .clk_in(ref_clk_in),
    .rst_n_in(rst_sync),
    .set_in(set_vec[4]),
    .clr_in(clr_vec[4]),
    .flag_out(error_passive_change_flag)
  );

  // error logging overflow flag
  cisf_flag u_log_overflow (
    .clk_in(ref_clk_in),
    .rst_n_in(rst_sync),
    .set_in(set_vec[3]),
    .clr_in(clr_vec[3]),
    .flag_out(error_log_overflow_flag)
  );

  // dedicated buffer stored flag
  cisf_flag u_buffer_stored (
    .clk_in(ref_clk_in),
    .rst_n_in(rst_sync),
    .set_in(set_vec[2]),
    .clr_in(clr_vec[2]),
    .flag_out(dedicated_buffer_stored_flag)
  );

  // timeout reached flag
  cisf_flag u_timeout (
    .clk_in(ref_clk_in),
    .rst_n_in(rst_sync),
    .set_in(set_vec[1]),
    .clr_in(clr_vec[1]),
    .flag_out(timeout_reached_flag)
  );

  // ram access failure flag
  cisf_flag u_access_failure (
    .clk_in(ref_clk_in),
    .rst_n_in(rst_sync),
    .set_in(set_vec[0]),
    .clr_in(clr_vec[0]),
    .flag_out(ram_access_failure_flag)
  );

  // place each flag at its bit of the word; all other bits read zero
  always @* begin
    next_flag_word = `CISF_FLAG_RESET;
    next_flag_word[`CISF_BIT_RAM_WATCHDOG] = ram_watchdog_flag;
    next_flag_word[`CISF_BIT_BUS_OFF_CHG] = bus_off_change_flag;
    next_flag_word[`CISF_BIT_WARNING_CHG] = error_warning_change_flag;
    next_flag_word[`CISF_BIT_PASSIVE_CHG] = error_passive_change_flag;
    next_flag_word[`CISF_BIT_LOG_OVERFLOW] = error_log_overflow_flag;
    next_flag_word[`CISF_BIT_DEDICATED_RX] = dedicated_buffer_stored_flag;
    next_flag_word[`CISF_BIT_TIMEOUT] = timeout_reached_flag;
    next_flag_word[`CISF_BIT_ACCESS_FAIL] = ram_access_failure_flag;
  end

  // flag word register, straight to the output
  always @(posedge ref_clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      flag_word_out <= `CISF_FLAG_RESET;
    end else begin
      flag_word_out <= next_flag_word;
    end
  end

  // abort pulse towards the receive handler
  always @(posedge ref_clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      store_abort_out <= 1'b0;
    end else begin
      store_abort_out <= next_store_abort;
    end
  end

  // fifo put advance pulse, only on a clean fifo store
  always @(posedge ref_clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      fifo_put_advance_out <= 1'b0;
    end else begin
      fifo_put_advance_out <= next_put_advance;
    end
  end

  // new-data pulse, only on a clean dedicated buffer store
  always @(posedge ref_clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      new_data_set_out <= 1'b0;
    end else begin
      new_data_set_out <= next_new_data_set;
    end
  end

  // buffer index held until the next clean dedicated store
  always @(posedge ref_clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      new_data_index_out <= {IDX_W{1'b0}};
    end else if (store_to_buffer) begin
      new_data_index_out <= store_index_in;
    end
  end

  // put index moves only on a clean fifo store, so a partial frame slot is rewritten
  always @(posedge ref_clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      fifo_put_index_out <= {IDX_W{1'b0}};
    end else if (store_to_fifo) begin
      fifo_put_index_out <= next_put_index;
    end
  end
endmodule
`default_nettype wire

// ### dv/cisf_props.sv
/* timing checks on the flag word and store controls.
   assumes binding to cisf_top and inputs changed away from the rising edge. */
`timescale 1ns/100ps
`default_nettype none
module cisf_props (
  input wire ref_clk_in,
  input wire rst_n_in,
  input wire ram_watchdog_expired_in,
  input wire bus_off_in,
  input wire error_warning_in,
  input wire error_passive_in,
  input wire error_log_overflow_in,
  input wire store_busy_in,
  input wire store_done_in,
  input wire store_dedicated_in,
  input wire next_arbitration_done_in,
  input wire ram_write_fail_in,
  input wire timeout_reached_in,
  input wire [31:0] flag_clear_in,
  input wire [31:0] flag_word_out,
  input wire store_abort_out,
  input wire fifo_put_advance_out,
  input wire new_data_set_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  // abort cause: overrun by the next frame or a failed write
  wire ab = ram_write_fail_in | (store_busy_in & next_arbitration_done_in);
  property p_wd; ram_watchdog_expired_in |-> ##2 flag_word_out[26]; endproperty
  a_wd: assert property (p_wd) else $error("watchdog flag missing");
  property p_off_chg; $changed(bus_off_in) |-> ##2 flag_word_out[25]; endproperty
  a_off_chg: assert property (p_off_chg) else $error("bus off flag missing");
  property p_warn_chg; $changed(error_warning_in) |-> ##2 flag_word_out[24]; endproperty
  a_warn_chg: assert property (p_warn_chg) else $error("warning flag missing");
  property p_pass_chg; $changed(error_passive_in) |-> ##2 flag_word_out[23]; endproperty
  a_pass_chg: assert property (p_pass_chg) else $error("passive flag missing");
  property p_lo; error_log_overflow_in |-> ##2 flag_word_out[22]; endproperty
  a_lo: assert property (p_lo) else $error("log overflow flag missing");
  property p_to; timeout_reached_in |-> ##2 flag_word_out[18]; endproperty
  a_to: assert property (p_to) else $error("timeout flag missing");
  property p_mr; ab |-> ##1 store_abort_out ##1 flag_word_out[17]; endproperty
  a_mr: assert property (p_mr) else $error("abort or failure flag missing");
  property p_nu; ab |-> ##1 !fifo_put_advance_out && !new_data_set_out; endproperty
  a_nu: assert property (p_nu) else $error("aborted store updated buffer");
  property p_dx; store_done_in && store_dedicated_in && !ab |-> ##1 new_data_set_out ##1 flag_word_out[19];
  endproperty
  a_dx: assert property (p_dx) else $error("dedicated store flag missing");
  property p_st; $fell(flag_word_out[17]) |-> $past(flag_clear_in[17], 2) && !$past(ab, 2); endproperty
  a_st: assert property (p_st) else $error("failure flag dropped");
endmodule
bind cisf_top cisf_props u_props (
  .ref_clk_in(ref_clk_in),
  .rst_n_in(rst_n_in),
  .ram_watchdog_expired_in(ram_watchdog_expired_in),
  .bus_off_in(bus_off_in),
  .error_warning_in(error_warning_in),
  .error_passive_in(error_passive_in),
  .error_log_overflow_in(error_log_overflow_in),
  .store_busy_in(store_busy_in),
  .store_done_in(store_done_in),
  .store_dedicated_in(store_dedicated_in),
  .next_arbitration_done_in(next_arbitration_done_in),
  .ram_write_fail_in(ram_write_fail_in),
  .timeout_reached_in(timeout_reached_in),
  .flag_clear_in(flag_clear_in),
  .flag_word_out(flag_word_out),
  .store_abort_out(store_abort_out),
  .fifo_put_advance_out(fifo_put_advance_out),
  .new_data_set_out(new_data_set_out)
);
`default_nettype wire

// ### dv/tb.sv
/* bench for cisf_top: table of flag events, then store, abort, clear and reset cases.
   assumes the rtl files and the checker are compiled first. */
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic ref_clk_in = 0, rst_n_in = 0, ram_watchdog_expired_in = 0, bus_off_in = 0, error_warning_in = 0;
  logic error_passive_in = 0, error_log_overflow_in = 0, store_busy_in = 0, store_done_in = 0;
  logic store_dedicated_in = 0, next_arbitration_done_in = 0, ram_write_fail_in = 0, timeout_reached_in = 0;
  logic [5:0] store_index_in = 6'h05, new_data_index_out, fifo_put_index_out, p0;
  logic [31:0] flag_clear_in = 32'h0, flag_word_out;
  logic store_abort_out, fifo_put_advance_out, new_data_set_out;
  int error_cnt = 0, n_tests = 0, cyc = 0;
  // event bits (watchdog, three state toggles, overflow, timeout, write failure) beside the expected word
  logic [38:0] rows [7] = '{{7'h40, 32'h04000000}, {7'h20, 32'h02000000}, {7'h10, 32'h01000000},
    {7'h08, 32'h00800000}, {7'h04, 32'h00400000}, {7'h02, 32'h00040000}, {7'h01, 32'h00020000}};
  cisf_top dut (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .ram_watchdog_expired_in(ram_watchdog_expired_in),
    .bus_off_in(bus_off_in),
    .error_warning_in(error_warning_in),
    .error_passive_in(error_passive_in),
    .error_log_overflow_in(error_log_overflow_in),
    .store_busy_in(store_busy_in),
    .store_done_in(store_done_in),
    .store_dedicated_in(store_dedicated_in),
    .store_index_in(store_index_in),
    .next_arbitration_done_in(next_arbitration_done_in),
    .ram_write_fail_in(ram_write_fail_in),
    .timeout_reached_in(timeout_reached_in),
    .flag_clear_in(flag_clear_in),
    .flag_word_out(flag_word_out),
    .store_abort_out(store_abort_out),
    .fifo_put_advance_out(fifo_put_advance_out),
    .new_data_set_out(new_data_set_out),
    .new_data_index_out(new_data_index_out),
    .fifo_put_index_out(fifo_put_index_out)
  );
  always #20 ref_clk_in = ~ref_clk_in;
  // hang guard
  always @(posedge ref_clk_in) if (++cyc > 400) begin
    error_cnt++;
    stop_test();
  end
  task automatic chk(input logic [31:0] e, input logic [31:0] s, input string nm);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask
  task automatic clr_all;
    flag_clear_in = 32'hFFFFFFFF;
    wt(1);
    flag_clear_in = 32'h0;
    wt(3);
    chk(32'h0, flag_word_out, "flag_word_out");
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    wt(2);
    rst_n_in = 1;
    wt(3);
    foreach (rows[i]) begin
      {ram_watchdog_expired_in, error_log_overflow_in, timeout_reached_in, ram_write_fail_in} =
        {rows[i][38], rows[i][34:32]};
      {bus_off_in, error_warning_in, error_passive_in} ^= rows[i][37:35];
      wt(1);
      {ram_watchdog_expired_in, error_log_overflow_in, timeout_reached_in, ram_write_fail_in} = 4'h0;
      wt(3);
      chk(rows[i][31:0], flag_word_out, "flag_word_out");
      clr_all();
      $display("event row %0d done", i);
    end
    // dedicated store, then an overrun abort with a store finishing alongside
    {store_done_in, store_dedicated_in} = 2'h3;
    wt(1);
    {store_done_in, store_dedicated_in} = 2'h0;
    chk(32'h1, {31'h0, new_data_set_out}, "new_data_set_out");
    wt(3);
    chk(32'h00080000, flag_word_out, "flag_word_out");
    chk({26'h0, 6'h05}, {26'h0, new_data_index_out}, "new_data_index_out");
    clr_all();
    p0 = fifo_put_index_out;
    {store_busy_in, next_arbitration_done_in, store_done_in} = 3'h7;
    wt(1);
    {store_busy_in, next_arbitration_done_in, store_done_in} = 3'h0;
    chk(32'h1, {31'h0, store_abort_out}, "store_abort_out");
    chk(32'h0, {31'h0, fifo_put_advance_out}, "fifo_put_advance_out");
    chk({26'h0, p0}, {26'h0, fifo_put_index_out}, "fifo_put_index_out");
    wt(3);
    chk(32'h00020000, flag_word_out, "flag_word_out");
    // one clean fifo store after the abort reuses the slot and moves the index on
    store_done_in = 1;
    wt(1);
    store_done_in = 0;
    chk(32'h1, {31'h0, fifo_put_advance_out}, "fifo_put_advance_out");
    chk({26'h0, p0 + 6'h01}, {26'h0, fifo_put_index_out}, "fifo_put_index_out");
    wt(3);
    // set and clear in the same cycle: set wins
    {ram_write_fail_in, flag_clear_in[17]} = 2'h3;
    wt(1);
    {ram_write_fail_in, flag_clear_in[17]} = 2'h0;
    wt(3);
    chk(32'h00020000, flag_word_out, "flag_word_out");
    // reset in mid-run wipes the flags and takes a new baseline
    rst_n_in = 0;
    wt(1);
    rst_n_in = 1;
    wt(4);
    chk(32'h0, flag_word_out, "flag_word_out");
    chk(32'h0, {26'h0, fifo_put_index_out}, "fifo_put_index_out");
    $display("store and reset tests done");
    stop_test();
  end
endmodule
`default_nettype wire
